// ===== include/epc_pkg.sv
// Package for the root-port control upper bits: offsets, fields, resets, types
package epc_pkg;

  localparam logic [7:0] PORT_STATUS_CONTROL_OFFSET = 8'h64;
  localparam logic [7:0] CONFIGURE_FLAG_REGISTER_OFFSET = 8'h60;

  // Field positions inside port_status_control
  localparam int WAKE_OC_BIT = 22;
  localparam int WAKE_DISC_BIT = 21;
  localparam int WAKE_CONN_BIT = 20;
  localparam int TEST_SEL_LSB = 16;
  localparam int OWNERSHIP_BIT = 13;
  localparam int POWER_BIT = 12;

  // Values after reset
  localparam logic RST_WAKE = 1'b0;
  localparam logic [3:0] RST_TEST_SEL = 4'h0;
  localparam logic RST_OWNERSHIP = 1'b1;
  localparam logic RST_POWER = 1'b0;

  // Test selector encodings
  localparam logic [3:0] TEST_DISABLED = 4'h0;
  localparam logic [3:0] TEST_J_STATE = 4'h1;
  localparam logic [3:0] TEST_K_STATE = 4'h2;
  localparam logic [3:0] TEST_SE0_NAK = 4'h3;
  localparam logic [3:0] TEST_PACKET = 4'h4;
  localparam logic [3:0] TEST_FORCE_ENABLE = 4'h5;

  typedef enum logic [2:0] {
    EPC_TM_NONE,
    EPC_TM_J,
    EPC_TM_K,
    EPC_TM_SE0_NAK,
    EPC_TM_PACKET,
    EPC_TM_FORCE_EN,
    EPC_TM_RESERVED
  } epc_test_mode_t;

  // Register write carrier
  typedef struct packed {
    logic wr_en;
    logic [7:0] addr;
    logic [31:0] wdata;
  } epc_reg_wr_t;

  // Port events from the lower port logic
  typedef struct packed {
    logic overcurrent;
    logic connect;
    logic disconnect;
  } epc_port_evt_t;

endpackage

// ===== src/epc_port_control.sv
// Upper bits of the root-port status and control register
`timescale 1ns/10ps
//
// Contract
// - Overcurrent wake enable resets low; when set, overcurrent raises a wake event.
// - Disconnect wake enable resets low; when set, disconnect raises a wake event.
// - Connect wake enable resets low; when set, connect raises a wake event.
// - Test selector resets to zero; zero is normal, nonzero selects a test mode.
// - Selector 1 J, 2 K, 3 SE0_NAK, 4 packet, 5 force enable, rest reserved.
// - Ownership resets high and clears when the configure flag rises.
// - Ownership is held high while the configure flag is low.
// - Ownership high routes the port to the companion controller.
// - Without power control capability the port is always powered; power reads one.
// - With power control capability the power bit drives and shows the switch.
// - With power off the port is nonfunctional and reports no status changes.
// - Overcurrent on a powered, switchable port may clear the power bit.
// - Configure flag low routes ports to companion; high routes them here unless ownership is set.
module epc_port_control (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Register access
  input epc_pkg::epc_reg_wr_t reg_wr,
  input wire logic [7:0] rd_addr,
  output logic [31:0] rd_data,
  // Configuration
  input wire logic configure_flag,
  input wire logic power_control_capability,
  // Port events from pins, asynchronous
  input epc_pkg::epc_port_evt_t port_evt_pin,
  // Port side
  output logic port_power_switch,
  output logic route_to_companion,
  output logic port_functional,
  output logic [2:0] test_mode,
  output logic wake_event
);

  logic wake_on_overcurrent_enable;
  logic wake_on_disconnect_enable;
  logic wake_on_connect_enable;
  logic [3:0] port_test_selector;
  logic port_ownership;
  logic port_power;
  logic cf_prev;
  epc_pkg::epc_port_evt_t evt_meta;
  epc_pkg::epc_port_evt_t evt_sync;
  epc_pkg::epc_port_evt_t evt_prev;
  epc_pkg::epc_test_mode_t next_mode;
  logic [31:0] reg_value;
  logic psc_wr;
  logic oc_rise;
  logic conn_rise;
  logic disc_rise;

  assign psc_wr = reg_wr.wr_en && (reg_wr.addr == epc_pkg::PORT_STATUS_CONTROL_OFFSET);

  // Two-stage sync of pin events
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      evt_meta <= '0;
      evt_sync <= '0;
      evt_prev <= '0;
    end else begin
      evt_meta <= port_evt_pin;
      evt_sync <= evt_meta;
      evt_prev <= evt_sync;
    end
  end

  assign oc_rise = evt_sync.overcurrent && !evt_prev.overcurrent;
  assign conn_rise = evt_sync.connect && !evt_prev.connect;
  assign disc_rise = evt_sync.disconnect && !evt_prev.disconnect;

  // Wake enables and test selector: plain read/write storage
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      wake_on_overcurrent_enable <= epc_pkg::RST_WAKE;
      wake_on_disconnect_enable <= epc_pkg::RST_WAKE;
      wake_on_connect_enable <= epc_pkg::RST_WAKE;
      port_test_selector <= epc_pkg::RST_TEST_SEL;
    end else if (psc_wr) begin
      wake_on_overcurrent_enable <= reg_wr.wdata[epc_pkg::WAKE_OC_BIT];
      wake_on_disconnect_enable <= reg_wr.wdata[epc_pkg::WAKE_DISC_BIT];
      wake_on_connect_enable <= reg_wr.wdata[epc_pkg::WAKE_CONN_BIT];
      port_test_selector <= reg_wr.wdata[epc_pkg::TEST_SEL_LSB +: 4];
    end
  end

  // Ownership: flag low forces one, rising flag clears, else software
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cf_prev <= 1'b0;
      port_ownership <= epc_pkg::RST_OWNERSHIP;
    end else begin
      cf_prev <= configure_flag;
      if (!configure_flag) begin
        port_ownership <= 1'b1;
      end else if (!cf_prev) begin
        port_ownership <= 1'b0;
      end else if (psc_wr) begin
        port_ownership <= reg_wr.wdata[epc_pkg::OWNERSHIP_BIT];
      end
    end
  end

  // Power bit; overcurrent cut beats a software write in the same cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      port_power <= epc_pkg::RST_POWER;
    end else if (!power_control_capability) begin
      port_power <= 1'b1;
    end else if (port_power && evt_sync.overcurrent) begin
      port_power <= 1'b0;
    end else if (psc_wr) begin
      port_power <= reg_wr.wdata[epc_pkg::POWER_BIT];
    end
  end

  epc_test_decode u_test_decode (
    .sel(port_test_selector),
    .mode(next_mode)
  );

  always_comb begin
    reg_value = '0;
    reg_value[epc_pkg::WAKE_OC_BIT] = wake_on_overcurrent_enable;
    reg_value[epc_pkg::WAKE_DISC_BIT] = wake_on_disconnect_enable;
    reg_value[epc_pkg::WAKE_CONN_BIT] = wake_on_connect_enable;
    reg_value[epc_pkg::TEST_SEL_LSB +: 4] = port_test_selector;
    reg_value[epc_pkg::OWNERSHIP_BIT] = port_ownership;
    reg_value[epc_pkg::POWER_BIT] = port_power || !power_control_capability;
  end

  // Registered outputs
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      rd_data <= '0;
      port_power_switch <= 1'b0;
      route_to_companion <= 1'b1;
      port_functional <= 1'b0;
      test_mode <= 3'h0;
      wake_event <= 1'b0;
    end else begin
      if (rd_addr == epc_pkg::PORT_STATUS_CONTROL_OFFSET) begin
        rd_data <= reg_value;
      end else begin
        rd_data <= '0;
      end
      port_power_switch <= port_power;
      route_to_companion <= port_ownership || !configure_flag;
      port_functional <= port_power;
      test_mode <= port_power ? next_mode : epc_pkg::EPC_TM_NONE;
      // Powered-off port reports nothing, so no wake either
      wake_event <= port_power &&
        ((wake_on_overcurrent_enable && oc_rise) ||
         (wake_on_disconnect_enable && disc_rise) ||
         (wake_on_connect_enable && conn_rise));
    end
  end

endmodule

// ===== src/epc_test_decode.sv
// Decoder from the test selector field to a test mode
`timescale 1ns/10ps
module epc_test_decode (
  // Selector in
  input wire logic [3:0] sel,
  // Decoded mode out
  output epc_pkg::epc_test_mode_t mode
);

  always_comb begin
    case (sel)
      epc_pkg::TEST_DISABLED: mode = epc_pkg::EPC_TM_NONE;
      epc_pkg::TEST_J_STATE: mode = epc_pkg::EPC_TM_J;
      epc_pkg::TEST_K_STATE: mode = epc_pkg::EPC_TM_K;
      epc_pkg::TEST_SE0_NAK: mode = epc_pkg::EPC_TM_SE0_NAK;
      epc_pkg::TEST_PACKET: mode = epc_pkg::EPC_TM_PACKET;
      epc_pkg::TEST_FORCE_ENABLE: mode = epc_pkg::EPC_TM_FORCE_EN;
      default: mode = epc_pkg::EPC_TM_RESERVED;
    endcase
  end

endmodule

// ===== tb/epc_port_control_assertions.sv
// Checker for the root-port control upper bits
`timescale 1ns/10ps
module epc_port_control_assertions (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Inputs
  input wire logic [7:0] rd_addr,
  input wire logic configure_flag,
  input wire logic power_control_capability,
  input epc_pkg::epc_port_evt_t port_evt_pin,
  // Outputs
  input wire logic [31:0] rd_data,
  input wire logic port_power_switch,
  input wire logic route_to_companion,
  input wire logic port_functional,
  input wire logic [2:0] test_mode,
  input wire logic wake_event
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  sequence s_oc_held;
    (power_control_capability && port_evt_pin.overcurrent) [*6];
  endsequence
  property p_cf_low; !configure_flag [*3] |-> route_to_companion; endproperty
  a_cf_low: assert property (p_cf_low) else $error("route low, flag low");
  property p_cf_rise; $rose(configure_flag) |-> ##[1:4] !route_to_companion; endproperty
  a_cf_rise: assert property (p_cf_rise) else $error("owner kept");
  // Pin edge lands on wake_event three edges later: two sync stages plus the output flop
  property p_wake; wake_event |-> $past(port_evt_pin, 3) != $past(port_evt_pin, 4); endproperty
  a_wake: assert property (p_wake) else $error("wake, no event");
  property p_oc_cut; s_oc_held |-> !port_power_switch; endproperty
  a_oc_cut: assert property (p_oc_cut) else $error("power kept");
  property p_unpowered; !port_functional [*2] |-> test_mode == 3'h0; endproperty
  a_unpowered: assert property (p_unpowered) else $error("mode unpowered");
  property p_mode; test_mode <= 3'h6; endproperty
  a_mode: assert property (p_mode) else $error("bad mode");
  property p_rd_other; rd_addr != 8'h64 |=> rd_data == 32'h0; endproperty
  a_rd_other: assert property (p_rd_other) else $error("stray read");
  property p_rsvd; (rd_data & 32'hff80_cfff) == 32'h0; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved set");
endmodule

// ===== tb/epc_usb_device_model.sv
// Downstream device model: attach and overcurrent levels
`timescale 1ns/10ps
module epc_usb_device_model (
  // Clock
  input wire logic clk_sys,
  // Bench commands
  input wire logic attach,
  input wire logic fault,
  // Port pins
  output epc_pkg::epc_port_evt_t port_evt_pin
);
  // Detach shows as a rising disconnect level
  always_ff @(posedge clk_sys) begin
    port_evt_pin.connect <= attach;
    port_evt_pin.disconnect <= !attach;
    port_evt_pin.overcurrent <= fault;
  end
endmodule

// ===== tb/tb_top.sv
// Testbench for the root-port control upper bits
`timescale 1ns/10ps
module tb_top;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  epc_pkg::epc_reg_wr_t reg_wr = '0;
  logic [7:0] rd_addr = 8'h00;
  logic configure_flag = 1'b0;
  logic power_control_capability = 1'b1;
  logic attach = 1'b0;
  logic fault = 1'b0;
  epc_pkg::epc_port_evt_t port_evt_pin;
  logic [31:0] rd_data;
  logic port_power_switch, route_to_companion, port_functional, wake_event;
  logic [2:0] test_mode;
  int miscompares = 0;
  int n_checks = 0;
  int pulses;
  epc_port_control u_epc_port_control (.clk_sys, .srst, .reg_wr, .rd_addr, .rd_data,
    .configure_flag, .power_control_capability, .port_evt_pin, .port_power_switch,
    .route_to_companion, .port_functional, .test_mode, .wake_event);
  epc_usb_device_model u_epc_usb_device_model (.clk_sys, .attach, .fault, .port_evt_pin);
  initial begin
    forever #50 clk_sys = ~clk_sys;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Write, then wait until read data shows it
  task automatic wr(input logic [31:0] data);
    @(posedge clk_sys);
    reg_wr <= '{1'b1, epc_pkg::PORT_STATUS_CONTROL_OFFSET, data};
    @(posedge clk_sys);
    reg_wr <= '0;
    repeat (3) @(posedge clk_sys);
    #1;
  endtask
  task automatic ev(input logic [31:0] en, input logic a, input logic f, input int exp);
    wr(en);
    @(posedge clk_sys);
    attach <= a;
    fault <= f;
    pulses = 0;
    repeat (8) begin
      @(posedge clk_sys);
      #1;
      if (wake_event === 1'b1) pulses++;
    end
    chk("wake pulses", exp, pulses);
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_sys);
    srst <= 1'b0;
    rd_addr <= epc_pkg::PORT_STATUS_CONTROL_OFFSET;
    repeat (3) @(posedge clk_sys);
    #1;
    chk("reset value", 32'h0000_2000, rd_data);
    wr(32'h0070_1000);
    chk("owner forced", 32'h0070_3000, rd_data);
    chk("switch", 1'b1, port_power_switch);
    chk("functional", 1'b1, port_functional);
    for (int s = 0; s < 16; s++) begin
      wr({12'h000, s[3:0], 16'h1000});
      chk("test mode", (s < 6) ? s : 6, test_mode);
    end
    $display("test registers done");
    @(posedge clk_sys);
    configure_flag <= 1'b1;
    wr(32'h0000_1000);
    chk("owner cleared", 32'h0000_1000, rd_data);
    chk("route", 1'b0, route_to_companion);
    wr(32'h0000_3000);
    chk("handed away", 1'b1, route_to_companion);
    @(posedge clk_sys);
    configure_flag <= 1'b0;
    $display("test ownership done");
    ev(32'h0010_1000, 1'b1, 1'b0, 1);
    ev(32'h0020_1000, 1'b0, 1'b0, 1);
    ev(32'h0000_1000, 1'b1, 1'b0, 0);
    ev(32'h0040_1000, 1'b1, 1'b1, 1);
    chk("oc cut", 32'h0040_2000, rd_data);
    chk("functional off", 1'b0, port_functional);
    ev(32'h0021_0000, 1'b0, 1'b0, 0);
    chk("mode unpowered", 3'h0, test_mode);
    @(posedge clk_sys);
    power_control_capability <= 1'b0;
    wr(32'h0021_0000);
    chk("always powered", 32'h0021_3000, rd_data);
    $display("test events done");
    summarize();
  end
endmodule
bind epc_port_control epc_port_control_assertions u_epc_port_control_assertions (.clk_sys,
  .srst, .rd_addr, .configure_flag, .power_control_capability, .port_evt_pin, .rd_data,
  .port_power_switch, .route_to_companion, .port_functional, .test_mode, .wake_event);
